/* File: rtl/ieu_pkg.sv */
package ieu_pkg;
	localparam int IW     = 14;
	localparam int DW     = 8;
	localparam int PCW    = 13;
	localparam int FAW    = 7;
	localparam int AXI_AW = 12;
	localparam int QUARTERS = 4;

	localparam logic [1:0] CLS_BYTE = 2'b00;
	localparam logic [1:0] CLS_BIT  = 2'b01;
	localparam logic [1:0] CLS_CTL  = 2'b10;
	localparam logic [1:0] CLS_LIT  = 2'b11;

	localparam logic [3:0] OP_MISC = 4'h0;
	localparam logic [3:0] OP_CLR  = 4'h1;
	localparam logic [3:0] OP_DEC  = 4'h3;
	localparam logic [3:0] OP_AND  = 4'h5;
	localparam logic [3:0] OP_ADD  = 4'h7;
	localparam logic [3:0] OP_COM  = 4'h9;
	localparam logic [3:0] OP_DSZ  = 4'hb;
	localparam logic [3:0] OP_ISZ  = 4'hf;
	localparam logic [2:0] LIT_ADD = 3'h7;
	localparam logic [3:0] LIT_AND = 4'h9;
	localparam logic [7:0] WATCHDOG_CLEAR_LOW = 8'h64;
	localparam logic [IW-1:0] NOP_WORD = 14'h0000;

	localparam int ST_C  = 0;
	localparam int ST_DIGIT     = 1;
	localparam int ST_Z         = 2;
	localparam int ST_POWERDOWN = 3;
	localparam int ST_TIMEOUT   = 4;
	localparam logic [DW-1:0] STATUS_RESET = 8'h18;
	localparam logic [FAW-1:0] FA_STATUS = 7'h03;
	localparam logic [FAW-1:0] FA_PC_HIGH = 7'h0a;

	localparam logic [AXI_AW-1:0] REG_CTRL  = 12'h000;
	localparam logic [AXI_AW-1:0] REG_PC    = 12'h004;
	localparam logic [AXI_AW-1:0] REG_WORK  = 12'h008;
	localparam logic [AXI_AW-1:0] REG_STACK = 12'h00c;
	localparam int CTRL_RUN = 0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PH_ADDR  = 2'b00,
		PH_READ  = 2'b01,
		PH_EXEC  = 2'b10,
		PH_WRITE = 2'b11
	} ieu_phase_t;

	typedef struct packed {
		logic [DW-1:0]  res;
		logic           c;
		logic           digit_carry_flag;
		logic           z;
		logic           upd_c;
		logic           upd_digit;
		logic           upd_z;
		logic           wr_acc;
		logic           wr_file;
		logic           skip;
		logic           branch;
		logic           push;
		logic           watchdog_clear;
		logic [PCW-1:0] target;
	} ieu_alu_t;

	typedef struct packed {
		logic [AXI_AW-1:0] awaddr;
		logic              awvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [AXI_AW-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} ieu_axi_in_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} ieu_axi_out_t;

	typedef struct packed {
		logic [FAW-1:0] addr;
		logic           we;
		logic [DW-1:0]  wdata;
	} ieu_file_t;
endpackage

/* File: rtl/ieu_alu.sv */
`timescale 1ns/10ps
module ieu_alu
	import ieu_pkg::*;
(
	input  wire logic [IW-1:0] instr,
	input  wire logic [DW-1:0] acc,
	input  wire logic [DW-1:0] opnd,
	input  wire logic [DW-1:0] pc_high_latch,
	output ieu_alu_t           alu_o
);
	logic [DW-1:0] addend;
	logic [DW:0]   sum;
	logic [4:0]    nib;
	logic [DW-1:0] bmask;
	logic          bit_v;
	logic          dest_op;

	always_comb begin
		alu_o = '0;
		dest_op = 1'b0;
		addend = (instr[13:12] == CLS_LIT) ? instr[7:0] : opnd;
		sum = {1'b0, acc} + {1'b0, addend};
		nib = {1'b0, acc[3:0]} + {1'b0, addend[3:0]};
		bmask = 8'h01 << instr[9:7];
		bit_v = |(opnd & bmask);
		alu_o.target = {pc_high_latch[4:3], instr[10:0]};
		case (instr[13:12])
			CLS_LIT: begin
				if (instr[11:9] == LIT_ADD) begin
					alu_o.res = sum[DW-1:0];
					alu_o.wr_acc = 1'b1;
					{alu_o.upd_c, alu_o.upd_digit, alu_o.upd_z} = 3'h7;
				end else if (instr[11:8] == LIT_AND) begin
					alu_o.res = acc & instr[7:0];
					alu_o.wr_acc = 1'b1;
					alu_o.upd_z = 1'b1;
				end
			end
			CLS_CTL: begin
				alu_o.branch = 1'b1;
				alu_o.push = !instr[11];
			end
			CLS_BIT: begin
				case (instr[11:10])
					2'b00: begin
						alu_o.res = opnd & ~bmask;
						alu_o.wr_file = 1'b1;
					end
					2'b01: begin
						alu_o.res = opnd | bmask;
						alu_o.wr_file = 1'b1;
					end
					2'b10: alu_o.skip = !bit_v;
					default: alu_o.skip = bit_v;
				endcase
			end
			default: begin
				case (instr[11:8])
					OP_ADD: begin
						alu_o.res = sum[DW-1:0];
						{alu_o.upd_c, alu_o.upd_digit, alu_o.upd_z} = 3'h7;
						dest_op = 1'b1;
					end
					OP_AND: begin
						alu_o.res = acc & opnd;
						alu_o.upd_z = 1'b1;
						dest_op = 1'b1;
					end
					OP_CLR: begin
						alu_o.upd_z = 1'b1;
						alu_o.wr_file = instr[7];
						alu_o.wr_acc = !instr[7];
					end
					OP_COM: begin
						alu_o.res = ~opnd;
						alu_o.upd_z = 1'b1;
						dest_op = 1'b1;
					end
					OP_DEC: begin
						alu_o.res = DW'(opnd - 8'h01);
						alu_o.upd_z = 1'b1;
						dest_op = 1'b1;
					end
					OP_DSZ: begin
						alu_o.res = DW'(opnd - 8'h01);
						alu_o.skip = (alu_o.res == 8'h00);
						dest_op = 1'b1;
					end
					OP_ISZ: begin
						alu_o.res = DW'(opnd + 8'h01);
						alu_o.skip = (alu_o.res == 8'h00);
						dest_op = 1'b1;
					end
					OP_MISC: alu_o.watchdog_clear = (instr[7:0] == WATCHDOG_CLEAR_LOW);
					default: ;
				endcase
			end
		endcase
		if (dest_op) begin
			alu_o.wr_acc = !instr[7];
			alu_o.wr_file = instr[7];
		end
		alu_o.c = sum[DW];
		alu_o.digit_carry_flag = nib[4];
		alu_o.z = (alu_o.res == 8'h00);
	end
endmodule

/* File: rtl/ieu_core.sv */
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
// What this block does
// - add literal into accumulator, carry flags, zero
// - and literal into accumulator, Z only
// - add accumulator and register, carry flags, zero
// - d bit picks accumulator or register
// - and accumulator with register, Z only
// - bit clear leaves other bits, no flags
// - bit set leaves other bits, no flags
// - skip next when tested bit clear
// - skip next when tested bit set
// - clear register and set Z
// - clear accumulator and set Z
// - call pushes return, loads target, two cycles
// - jump loads target without stack, two cycles
// - watchdog clear zeroes counter, sets timeout, powerdown
// - decrement register, Z only
// - decrement, skip next on zero result
// - increment, skip next on zero result
// - four clocks per instruction cycle
// - bit ops read, modify, write whole byte
// - instruction flags override status writes
module ieu_core
	import ieu_pkg::*;
#(
	parameter int STACK_DEPTH = 8
)(
	input  wire logic           aclk,
	input  wire logic           aresetn,
	input  ieu_axi_in_t         axi_i,
	output ieu_axi_out_t        axi_o,
	output logic [PCW-1:0]      prog_addr,
	input  wire logic [IW-1:0]  prog_data,
	output ieu_file_t           file_o,
	input  wire logic [DW-1:0]  file_rdata
);
	localparam int SPW = $clog2(STACK_DEPTH);

	typedef struct packed {
		ieu_phase_t                       phase;
		logic                             run;
		logic [IW-1:0]                    instr;
		logic [PCW-1:0]                   pc;
		logic [DW-1:0]                    acc;
		logic [DW-1:0]                    status;
		logic [DW-1:0]                    pc_high_latch;
		logic [DW-1:0]                    opnd;
		logic [DW-1:0]                    watchdog_counter;
		logic [DW-1:0]                    watchdog_prescale;
		logic [STACK_DEPTH-1:0][PCW-1:0]  stack;
		logic [SPW-1:0]                   sp;
		ieu_file_t                        file;
		ieu_axi_out_t                     axo;
	} ieu_state_t;

	ieu_state_t     q;
	ieu_state_t     d;
	ieu_alu_t       alu;
	logic [PCW-1:0] top_of_stack;
	logic [DW-1:0]  st;

	function automatic logic is_local(input logic [FAW-1:0] a);
		return (a == FA_STATUS) || (a == FA_PC_HIGH);
	endfunction

	function automatic logic reg_hit(input logic [AXI_AW-1:0] a);
		return (a == REG_CTRL) || (a == REG_PC) || (a == REG_WORK) || (a == REG_STACK);
	endfunction

	ieu_alu u_alu (
		.instr  (q.instr),
		.acc    (q.acc),
		.opnd   (q.opnd),
		.pc_high_latch (q.pc_high_latch),
		.alu_o  (alu)
	);

	assign top_of_stack = q.stack[SPW'(q.sp - 1'b1)];
	assign axi_o = q.axo;
	assign prog_addr = q.pc;
	assign file_o = q.file;

	always_comb begin
		d = q;
		st = q.status;
		d.file.we = 1'b0;

		// write channel: address and data are taken together
		d.axo.awready = axi_i.awvalid && axi_i.wvalid && !q.axo.awready && !q.axo.bvalid;
		d.axo.wready = d.axo.awready;
		if (q.axo.awready) begin
			d.axo.bvalid = 1'b1;
			d.axo.bresp = reg_hit(axi_i.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (axi_i.awaddr == REG_CTRL && axi_i.wstrb[0]) begin
				d.run = axi_i.wdata[CTRL_RUN];
			end
		end else if (q.axo.bvalid && axi_i.bready) begin
			d.axo.bvalid = 1'b0;
		end

		// read channel
		d.axo.arready = axi_i.arvalid && !q.axo.arready && !q.axo.rvalid;
		if (q.axo.arready) begin
			d.axo.rvalid = 1'b1;
			d.axo.rresp = reg_hit(axi_i.araddr) ? RESP_OKAY : RESP_SLVERR;
			case (axi_i.araddr)
				REG_CTRL:  d.axo.rdata = 32'(q.run);
				REG_PC:    d.axo.rdata = 32'({q.sp, q.pc});
				REG_WORK:  d.axo.rdata = 32'({q.pc_high_latch, q.status, q.acc});
				REG_STACK: d.axo.rdata = 32'({q.watchdog_counter, top_of_stack});
				default:   d.axo.rdata = 32'h0000_0000;
			endcase
		end else if (q.axo.rvalid && axi_i.rready) begin
			d.axo.rvalid = 1'b0;
		end

		case (q.phase)
			PH_ADDR: begin
				// stop only between instructions so none is torn
				if (q.run) begin
					d.file.addr = q.instr[FAW-1:0];
					d.phase = PH_READ;
				end
			end
			PH_READ: begin
				if (q.file.addr == FA_STATUS) begin
					d.opnd = q.status;
				end else if (q.file.addr == FA_PC_HIGH) begin
					d.opnd = q.pc_high_latch;
				end else begin
					d.opnd = file_rdata;
				end
				d.phase = PH_EXEC;
			end
			PH_EXEC: begin
				d.file.we = alu.wr_file && !is_local(q.file.addr);
				d.file.wdata = alu.res;
				d.phase = PH_WRITE;
			end
			PH_WRITE: begin
				if (alu.wr_acc) begin
					d.acc = alu.res;
				end
				if (alu.wr_file && q.file.addr == FA_PC_HIGH) begin
					d.pc_high_latch = alu.res;
				end
				if (alu.wr_file && q.file.addr == FA_STATUS) begin
					st = alu.res;
				end
				if (alu.upd_c) begin
					st[ST_C] = alu.c;
				end
				if (alu.upd_digit) begin
					st[ST_DIGIT] = alu.digit_carry_flag;
				end
				if (alu.upd_z) begin
					st[ST_Z] = alu.z;
				end
				// free-running watchdog, prescaled per instruction cycle
				{d.watchdog_counter, d.watchdog_prescale} =
					16'({q.watchdog_counter, q.watchdog_prescale} + 16'h0001);
				if (&{q.watchdog_counter, q.watchdog_prescale}) begin
					st[ST_TIMEOUT] = 1'b0;
				end
				if (alu.watchdog_clear) begin
					d.watchdog_counter = '0;
					d.watchdog_prescale = '0;
					st[ST_TIMEOUT] = 1'b1;
					st[ST_POWERDOWN] = 1'b1;
				end
				d.status = st;
				if (alu.push) begin
					d.stack[q.sp] = q.pc;
					d.sp = SPW'(q.sp + 1'b1);
				end
				d.pc = alu.branch ? alu.target : PCW'(q.pc + 1'b1);
				d.instr = (alu.branch || alu.skip) ? NOP_WORD : prog_data;
				d.phase = PH_ADDR;
			end
			default: d.phase = PH_ADDR;
		endcase
	end

	// stack wraps silently when deeper than STACK_DEPTH
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.status <= STATUS_RESET;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	logic exec_w;
	assign exec_w = (q.phase == PH_WRITE);

	sequence s_cycle;
		q.phase == PH_READ ##1 q.phase == PH_EXEC ##1 q.phase == PH_WRITE
		##1 q.phase == PH_ADDR;
	endsequence

	sequence s_call;
		exec_w && q.instr[13:11] == 3'b100;
	endsequence

	sequence s_skip;
		exec_w && alu.skip && !alu.branch;
	endsequence

	chk_cycle_len: assert property (
		(q.phase == PH_ADDR && q.run) |=> s_cycle
	) else $error("instruction cycle not four clocks");

	chk_add_literal: assert property (
		(exec_w && q.instr[13:9] == 5'h1f)
		|=> (q.acc == 8'($past(q.acc) + $past(q.instr[7:0])))
		&& (q.status[ST_C] == $past(alu.c))
	) else $error("add literal result wrong");

	chk_and_literal: assert property (
		(exec_w && q.instr[13:8] == 6'h39)
		|=> (q.acc == ($past(q.acc) & $past(q.instr[7:0])))
		&& $stable(q.status[ST_C]) && (q.status[ST_Z] == (q.acc == 8'h00))
	) else $error("and literal result wrong");

	chk_bit_clear: assert property (
		(q.phase == PH_EXEC && q.instr[13:10] == 4'h4 && !is_local(q.file.addr))
		|=> q.file.we && (q.file.wdata == ($past(q.opnd) & ~(8'h01 << $past(q.instr[9:7]))))
	) else $error("bit clear wrote wrong byte");

	chk_skip_nop: assert property (
		s_skip |=> (q.instr == NOP_WORD) && (q.pc == $past(q.pc) + 1'b1)
	) else $error("skipped instruction not replaced");

	chk_call_push: assert property (
		s_call |=> (top_of_stack == $past(q.pc)) && (q.pc == $past(alu.target))
		&& (q.instr == NOP_WORD)
	) else $error("call did not push or load");

	chk_jump_nostack: assert property (
		(exec_w && q.instr[13:11] == 3'b101)
		|=> (q.sp == $past(q.sp))
		&& (q.pc == {$past(q.pc_high_latch[4:3]), $past(q.instr[10:0])})
	) else $error("jump target or stack wrong");

	chk_wdt_clear: assert property (
		(exec_w && q.instr == 14'h0064)
		|=> (q.watchdog_counter == 8'h00) && (q.watchdog_prescale == 8'h00)
		&& q.status[ST_TIMEOUT] && q.status[ST_POWERDOWN]
	) else $error("watchdog clear incomplete");

	chk_clear_zero: assert property (
		(exec_w && q.instr[13:7] == 7'h03) |=> q.status[ST_Z]
	) else $error("clear register left Z low");

	chk_dest_acc: assert property (
		(q.phase == PH_EXEC && q.instr[13:12] == CLS_BYTE && !q.instr[7])
		|=> !q.file.we
	) else $error("destination zero wrote register");
endmodule

/* File: testbench/ieu_mem_model.sv */
`timescale 1ns/10ps
module ieu_mem_model
	import ieu_pkg::*;
(
	input  wire logic           aclk,
	input  wire logic [PCW-1:0] prog_addr,
	output logic [IW-1:0]       prog_data,
	input  ieu_file_t           file_i,
	output logic [DW-1:0]       file_rdata,
	input  wire logic           ld_we,
	input  wire logic           ld_file,
	input  wire logic [PCW-1:0] ld_addr,
	input  wire logic [IW-1:0]  ld_data,
	input  wire logic [FAW-1:0] pk_addr,
	output logic [DW-1:0]       pk_data
);
	logic [IW-1:0] prog_q [2**PCW];
	logic [DW-1:0] file_q [2**FAW];
	// plain async read, as the core samples late in the phase
	assign prog_data  = prog_q[prog_addr];
	assign file_rdata = file_q[file_i.addr];
	assign pk_data    = file_q[pk_addr];
	// unwritten words read as no-op, so stray fetches stay harmless
	initial begin
		foreach (prog_q[i]) prog_q[i] = NOP_WORD;
		foreach (file_q[i]) file_q[i] = 8'h00;
	end
	always @(posedge aclk) begin
		if (ld_we && !ld_file) prog_q[ld_addr] <= ld_data;
		if (ld_we && ld_file) file_q[ld_addr[FAW-1:0]] <= ld_data[DW-1:0];
		if (file_i.we) file_q[file_i.addr] <= file_i.wdata;
	end
endmodule

/* File: testbench/instruction_execute_unit_a_to_i_bench.sv */
`timescale 1ns/10ps
module instruction_execute_unit_a_to_i_bench
	import ieu_pkg::*;
;
	localparam logic [IW-1:0] P2 [17] = '{14'h13b0, 14'h15b0, 14'h1a30, 14'h3e01, 14'h1c30,
		14'h3e02, 14'h1830, 14'h3e04, 14'h0bb1, 14'h3e08, 14'h0fb2, 14'h3e10, 14'h0fb3,
		14'h3e20, 14'h01b4, 14'h0183, 14'h2810};
	localparam logic [PCW-1:0] A3 [11] = '{13'h0000, 13'h0001, 13'h0004, 13'h0005, 13'h0006,
		13'h0007, 13'h0008, 13'h0009, 13'h000a, 13'h0810, 13'h0811};
	localparam logic [IW-1:0] D3 [11] = '{14'h2004, 14'h3e40, 14'h1203, 14'h1183, 14'h0064,
		14'h017f, 14'h158a, 14'h2810, 14'h3e40, 14'h3e05, 14'h2811};
	logic           aclk;
	logic           aresetn;
	ieu_axi_in_t    axi_i;
	ieu_axi_out_t   axi_o;
	logic [PCW-1:0] prog_addr;
	logic [IW-1:0]  prog_data;
	ieu_file_t      file_o;
	logic [DW-1:0]  file_rdata;
	logic           ld_we;
	logic           ld_file;
	logic [PCW-1:0] ld_addr;
	logic [IW-1:0]  ld_data;
	logic [FAW-1:0] pk_addr;
	logic [DW-1:0]  pk_data;
	logic [31:0]    rd_q;
	logic [1:0]     resp_q;
	int             miscompares;
	int             tests_run;

	ieu_core dut_u (.aclk(aclk), .aresetn(aresetn), .axi_i(axi_i), .axi_o(axi_o),
		.prog_addr(prog_addr), .prog_data(prog_data), .file_o(file_o),
		.file_rdata(file_rdata));
	ieu_mem_model mem_u (.aclk(aclk), .prog_addr(prog_addr), .prog_data(prog_data),
		.file_i(file_o), .file_rdata(file_rdata), .ld_we(ld_we), .ld_file(ld_file),
		.ld_addr(ld_addr), .ld_data(ld_data), .pk_addr(pk_addr), .pk_data(pk_data));

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	function automatic logic [7:0] st(input logic c, input logic digit, input logic z);
		return {3'b000, 2'b11, z, digit, c};
	endfunction
	// carry out of bit 7 and of bit 3
	function automatic logic [1:0] add_cd(input logic [7:0] a, input logic [7:0] b);
		return {(9'(a) + 9'(b)) > 9'h0ff, (5'(a[3:0]) + 5'(b[3:0])) > 5'h0f};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		axi_i.awaddr  <= a;
		axi_i.awvalid <= 1'b1;
		axi_i.wdata   <= d;
		axi_i.wstrb   <= 4'hf;
		axi_i.wvalid  <= 1'b1;
		axi_i.bready  <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (axi_o.awready === 1'b1) axi_i.awvalid <= 1'b0;
			if (axi_o.wready === 1'b1) axi_i.wvalid <= 1'b0;
		end while (axi_o.bvalid !== 1'b1 && n < 64);
		resp_q = axi_o.bresp;
		axi_i.bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [AXI_AW-1:0] a);
		int n;
		@(posedge aclk);
		axi_i.araddr  <= a;
		axi_i.arvalid <= 1'b1;
		axi_i.rready  <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (axi_o.arready === 1'b1) axi_i.arvalid <= 1'b0;
		end while (axi_o.rvalid !== 1'b1 && n < 64);
		rd_q   = axi_o.rdata;
		resp_q = axi_o.rresp;
		axi_i.rready <= 1'b0;
	endtask
	task automatic restart();
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task automatic ld(input logic f, input logic [PCW-1:0] a, input logic [IW-1:0] d);
		@(posedge aclk);
		ld_we   <= 1'b1;
		ld_file <= f;
		ld_addr <= a;
		ld_data <= d;
		@(posedge aclk);
		ld_we <= 1'b0;
	endtask
	// stop lands at phase 0, so a short tail lets the last cycle finish
	task automatic run(input int cyc);
		axi_wr(REG_CTRL, 32'h0000_0001);
		chk(32'(resp_q), 32'(RESP_OKAY));
		repeat (cyc * QUARTERS) @(posedge aclk);
		axi_wr(REG_CTRL, 32'h0000_0000);
		repeat (2 * QUARTERS) @(posedge aclk);
	endtask
	task automatic fchk(input logic [FAW-1:0] a, input logic [DW-1:0] e);
		pk_addr <= a;
		@(posedge aclk);
		#1;
		chk({24'h00_0000, pk_data}, {24'h00_0000, e});
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		end_sim();
	end

	initial begin
		logic [7:0] k, a, b, c, d, m, s;
		logic [1:0] cd;
		aresetn     = 1'b0;
		axi_i       = '0;
		ld_we       = 1'b0;
		ld_file     = 1'b0;
		ld_addr     = '0;
		ld_data     = '0;
		pk_addr     = '0;
		miscompares = 0;
		tests_run   = 0;
		void'($urandom(32'h2bf0_6a7e));
		for (int i = 0; i < 4; i++) begin
			k = (i == 0) ? 8'hff : 8'($urandom);
			a = (i == 0) ? 8'h01 : 8'($urandom);
			b = 8'($urandom);
			c = 8'($urandom);
			d = 8'($urandom);
			m = (i == 0) ? 8'h00 : 8'($urandom);
			restart();
			ld(1'b1, 13'h0020, {6'h00, a});
			ld(1'b1, 13'h0021, {6'h00, b});
			ld(1'b1, 13'h0022, {6'h00, c});
			ld(1'b1, 13'h0023, {6'h00, d});
			ld(1'b0, 13'h0000, {5'h1f, 1'($urandom), k});
			ld(1'b0, 13'h0001, 14'h0720);
			ld(1'b0, 13'h0002, 14'h05a1);
			ld(1'b0, 13'h0003, 14'h09a2);
			ld(1'b0, 13'h0004, 14'h0323);
			ld(1'b0, 13'h0005, {6'h39, m});
			ld(1'b0, 13'h0006, 14'h2806);
			run(12);
			cd = add_cd(k, a);
			s  = (d - 8'h01) & m;
			axi_rd(REG_WORK);
			chk(rd_q, {16'h0000, st(cd[1], cd[0], s == 8'h00), s});
			fchk(7'h20, a);
			fchk(7'h21, (k + a) & b);
			fchk(7'h22, ~c);
			fchk(7'h23, d);
			$display("test arith %0d done", i);
		end
		restart();
		ld(1'b1, 13'h0030, 14'h00c7);
		ld(1'b1, 13'h0031, 14'h0001);
		ld(1'b1, 13'h0032, 14'h00ff);
		ld(1'b1, 13'h0033, 14'h0005);
		ld(1'b1, 13'h0034, 14'h005a);
		for (int j = 0; j < 17; j++) begin
			ld(1'b0, 13'(j), P2[j]);
		end
		run(28);
		axi_rd(REG_WORK);
		chk(rd_q, 32'h0000_0424);
		fchk(7'h30, 8'h4f);
		fchk(7'h31, 8'h00);
		fchk(7'h32, 8'h00);
		fchk(7'h33, 8'h06);
		fchk(7'h34, 8'h00);
		$display("test bits skips done");
		restart();
		for (int j = 0; j < 11; j++) begin
			ld(1'b0, A3[j], D3[j]);
		end
		run(24);
		axi_rd(REG_WORK);
		chk(rd_q, 32'h0008_1805);
		axi_rd(REG_STACK);
		chk(rd_q & 32'h001f_ffff, 32'h0000_0001);
		axi_wr(REG_PC, 32'h0000_0000);
		chk(32'(resp_q), 32'(RESP_OKAY));
		axi_rd(REG_PC);
		chk(32'(rd_q[15:13]), 32'h0000_0001);
		axi_rd(12'h010);
		chk({rd_q[29:0], resp_q}, {30'h0000_0000, RESP_SLVERR});
		$display("test branch done");
		end_sim();
	end
endmodule
